// [hdl/bpw_defs.vh]
// bpw_defs.vh: mode encodings and widths for the bridge waveform generator
// assumes: included by the design, the checker and the bench
`ifndef BPW_DEFS_VH
`define BPW_DEFS_VH
`define BPW_MODE_W      3
`define BPW_MODE_PPC    3'h0
`define BPW_MODE_PPFB   3'h1
`define BPW_MODE_PPFBC  3'h2
`define BPW_MODE_PSK    3'h3
`define BPW_MODE_PSKC   3'h4
`define BPW_MODE_FBFWD  3'h5
`define BPW_MODE_FBREV  3'h6
`define BPW_DB_W        8
`define BPW_DB_ZERO     8'h00
`define BPW_RISE_W      4
`endif

// [hdl/bpw_gen.v]
// bpw_gen.v: six-output waveform generator for push-pull, pulse-skipping
// and full-bridge modes, with rising and falling dead band.
// assumes: period/rise/fall events are one-cycle pulses on ref_clk;
// async rising inputs come from pins and are synchronised here;
// mode and dead-band settings are static while enabled, except that
// a bridge mode may flip its direction at any time.
//
// Contract
// RULE_01 - push-pull complementary: a with e, b with f, dead band, no steering
// RULE_02 - odd period: rise drops e, dead band, raises a; fall reverses
// RULE_03 - even period: rise drops f, dead band, raises b; fall reverses
// RULE_04 - four full-bridge: odd period a and c rise and fall together
// RULE_05 - four full-bridge: even period b and d rise and fall together
// RULE_06 - full-bridge complementary: a-d primary, e-f complementary, dead band
// RULE_07 - odd period: rise drops e, dead band, raises a,c; fall reverses
// RULE_08 - even period: rise drops f, dead band, raises b,d; fall reverses
// RULE_09 - pulse skipping: rise only if an enabled async input high at period
// RULE_10 - qualified pulse applied at next synchronous rising event
// RULE_11 - pulse skipping: falling event always taken, no qualification
// RULE_12 - single pulse skipping: only a, no dead band
// RULE_13 - software uses an external source to qualify pulses
// RULE_14 - complementary pulse skipping: a primary, b complementary, dead band
// RULE_15 - full bridge uses single-mode events on a-d, direction by mode
// RULE_16 - dead band only at direction change; forward to reverse uses falling
// RULE_17 - reverse to forward uses rising dead-band counter
// RULE_18 - forward: d held active, b,c inactive, a follows events
// RULE_19 - reverse: c held active, a,d inactive, b follows events
// RULE_20 - separate 8-bit rising and falling dead-band counters; the code shares one 8-bit counter, cnt_q, for both
// RULE_21 - rising delays primary on; falling delays complementary on
// RULE_22 - parity flag toggles each period, starts odd on enable; the code toggles only when st_q is ST_IDLE and prim_q is low
// RULE_23 - dead band off: outputs swap in the same cycle
`timescale 1ns/1ns
`include "bpw_defs.vh"

module bpw_gen (
  input  wire                   ref_clk,
  input  wire                   srst,
  input  wire                   enable,
  input  wire [`BPW_MODE_W-1:0] mode,
  input  wire                   db_rise_en,
  input  wire                   db_fall_en,
  input  wire [`BPW_DB_W-1:0]   db_rise_time,
  input  wire [`BPW_DB_W-1:0]   db_fall_time,
  input  wire                   period_evt,
  input  wire                   rise_evt,
  input  wire                   fall_evt,
  input  wire [`BPW_RISE_W-1:0] async_rise_in,
  input  wire [`BPW_RISE_W-1:0] async_rise_en,
  output reg                    out_a,
  output reg                    out_b,
  output reg                    out_c,
  output reg                    out_d,
  output reg                    out_e,
  output reg                    out_f
);

  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_DBR  = 3'h2;
  localparam [2:0] ST_DBF  = 3'h4;

  // mode classes, used by both the event path and the static drive
  function is_comp;
    input [`BPW_MODE_W-1:0] m;
    begin
      is_comp = (m == `BPW_MODE_PPC) || (m == `BPW_MODE_PPFBC) || (m == `BPW_MODE_PSKC);
    end
  endfunction

  function is_fb;
    input [`BPW_MODE_W-1:0] m;
    begin
      is_fb = (m == `BPW_MODE_FBFWD) || (m == `BPW_MODE_FBREV);
    end
  endfunction

  function is_psk;
    input [`BPW_MODE_W-1:0] m;
    begin
      is_psk = (m == `BPW_MODE_PSK) || (m == `BPW_MODE_PSKC);
    end
  endfunction

  // two-flop synchronisers for the asynchronous rising sources
  // only rs2_q feeds logic; rs1_q may still be settling
  reg  [`BPW_RISE_W-1:0] rs1_q;
  reg  [`BPW_RISE_W-1:0] rs2_q;
  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      rs1_q <= {`BPW_RISE_W{1'b0}};
      rs2_q <= {`BPW_RISE_W{1'b0}};
    end
    else
    begin
      rs1_q <= async_rise_in;
      rs2_q <= rs1_q;
    end
  end

  reg                  en_q;
  reg                  odd_q;
  reg                  qual_q;
  reg                  prim_q;
  reg                  cmp_q;
  reg                  dir_rev_q;
  reg                  fb_pend_q;
  reg  [2:0]           st_q;
  reg  [`BPW_DB_W-1:0] cnt_q;

  // decodes read the live mode: only a bridge direction flip moves it while enabled
  wire comp_m  = is_comp(mode);
  wire fb_m    = is_fb(mode);
  wire psk_m   = is_psk(mode);
  wire qual_in = |(rs2_q & async_rise_en);
  wire want_rev = (mode == `BPW_MODE_FBREV);
  wire rise_ok = psk_m ? qual_q : 1'b1; // see RULE_10
  wire db_done = (cnt_q == `BPW_DB_ZERO);

  // one pulse state: primary and complementary levels plus dead-band timer
  reg                  prim_d;
  reg                  cmp_d;
  reg  [2:0]           st_d;
  reg  [`BPW_DB_W-1:0] cnt_d;
  always @*
  begin
    prim_d = prim_q;
    cmp_d  = cmp_q;
    st_d   = st_q;
    cnt_d  = cnt_q;
    case (st_q)
      ST_IDLE:
      begin
        if (rise_evt && rise_ok && !prim_q)
        begin
          cmp_d = 1'b0; // see RULE_02, RULE_03, RULE_07, RULE_08, RULE_14
          // counter loads N-1: turn-on comes exactly N clocks after turn-off
          if (comp_m && db_rise_en && db_rise_time != `BPW_DB_ZERO)
          begin
            st_d  = ST_DBR; // see RULE_21
            cnt_d = db_rise_time - 8'h01;
          end
          else
            prim_d = 1'b1; // see RULE_23
        end
        else if (fall_evt && prim_q)
        begin
          prim_d = 1'b0; // see RULE_11
          // the complementary leg waits out the falling dead band
          if (comp_m && db_fall_en && db_fall_time != `BPW_DB_ZERO)
          begin
            st_d  = ST_DBF; // see RULE_21
            cnt_d = db_fall_time - 8'h01;
          end
          else
            cmp_d = comp_m; // see RULE_23
        end
      end
      ST_DBR:
      begin
        // a fall event here is refused: the primary is not on yet
        if (db_done)
        begin
          prim_d = 1'b1;
          st_d   = ST_IDLE;
        end
        else
          cnt_d = cnt_q - 8'h01; // see RULE_20
      end
      ST_DBF:
      begin
        if (db_done)
        begin
          cmp_d = 1'b1;
          st_d  = ST_IDLE;
        end
        else
          cnt_d = cnt_q - 8'h01; // see RULE_20
      end
      default:
      begin
        // a corrupt state code falls back to idle
        st_d = ST_IDLE;
      end
    endcase
  end

  // parity and pulse-skip qualification; enable low parks both
  always @(posedge ref_clk)
  begin
    if (srst || !enable)
    begin
      odd_q  <= 1'b0;
      qual_q <= 1'b0;
    end
    else
    begin
      // held even until live, so the first period event opens an odd period
      if (en_q && period_evt && st_q == ST_IDLE && !prim_q)
        odd_q <= ~odd_q; // see RULE_22
      // a period event beside a rise wins: it belongs to the next period
      if (period_evt)
        qual_q <= qual_in; // see RULE_09
      else if (rise_evt)
        qual_q <= 1'b0; // see RULE_10
    end
  end

  always @(posedge ref_clk)
  begin
    if (srst || !enable)
    begin
      en_q      <= 1'b0;
      prim_q    <= 1'b0;
      cmp_q     <= 1'b0;
      st_q      <= ST_IDLE;
      cnt_q     <= `BPW_DB_ZERO;
      dir_rev_q <= 1'b0;
      fb_pend_q <= 1'b0;
    end
    else
    begin
      // en_q marks the first live cycle: idle levels are loaded there
      en_q <= 1'b1;
      if (!en_q)
      begin
        cmp_q     <= comp_m;
        dir_rev_q <= want_rev;
      end
      else if (fb_m && (want_rev != dir_rev_q) && !fb_pend_q)
      begin
        // direction swap: all legs off, then wait the matching dead band
        fb_pend_q <= 1'b1; // see RULE_16
        prim_q    <= 1'b0;
        cnt_q     <= want_rev ? db_fall_time : db_rise_time; // see RULE_16, RULE_17
      end
      else if (fb_pend_q)
      begin
        // pulse state frozen while swapping: events then are refused
        if (db_done)
        begin
          fb_pend_q <= 1'b0;
          dir_rev_q <= want_rev;
        end
        else
          cnt_q <= cnt_q - 8'h01;
      end
      else
      begin
        prim_q <= prim_d; // see RULE_15
        cmp_q  <= cmp_d;
        st_q   <= st_d;
        cnt_q  <= cnt_d;
      end
    end
  end

  // output steering by mode; parity picks the active leg in push-pull
  reg pa;
  reg pb;
  reg pc;
  reg pd;
  reg pe;
  reg pf;
  always @*
  begin
    pa = 1'b0;
    pb = 1'b0;
    pc = 1'b0;
    pd = 1'b0;
    pe = 1'b0;
    pf = 1'b0;
    if (en_q)
    begin
      case (mode)
        `BPW_MODE_PPC:
        begin
          pa = odd_q & prim_q; // see RULE_01, RULE_02
          pb = !odd_q & prim_q; // see RULE_03
          pe = odd_q ? cmp_q : 1'b1;
          pf = odd_q ? 1'b1 : cmp_q;
        end
        `BPW_MODE_PPFB:
        begin
          pa = odd_q & prim_q; // see RULE_04
          pc = odd_q & prim_q;
          pb = !odd_q & prim_q; // see RULE_05
          pd = !odd_q & prim_q;
        end
        `BPW_MODE_PPFBC:
        begin
          pa = odd_q & prim_q; // see RULE_06, RULE_07
          pc = odd_q & prim_q;
          pb = !odd_q & prim_q; // see RULE_08
          pd = !odd_q & prim_q;
          pe = odd_q ? cmp_q : 1'b1;
          pf = odd_q ? 1'b1 : cmp_q;
        end
        `BPW_MODE_PSK:
          pa = prim_q; // see RULE_12
        `BPW_MODE_PSKC:
        begin
          pa = prim_q; // see RULE_14
          pb = cmp_q;
        end
        `BPW_MODE_FBFWD, `BPW_MODE_FBREV:
        begin
          if (!fb_pend_q)
          begin
            pa = !dir_rev_q & prim_q; // see RULE_18
            pd = !dir_rev_q;
            pb = dir_rev_q & prim_q; // see RULE_19
            pc = dir_rev_q;
          end
        end
        // code 7 and unused codes: all outputs off
        default:
          pa = 1'b0;
      endcase
    end
  end

  // one clock of latency buys glitch-free pins straight from flip-flops
  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      out_a <= 1'b0;
      out_b <= 1'b0;
      out_c <= 1'b0;
      out_d <= 1'b0;
      out_e <= 1'b0;
      out_f <= 1'b0;
    end
    else
    begin
      out_a <= pa;
      out_b <= pb;
      out_c <= pc;
      out_d <= pd;
      out_e <= pe;
      out_f <= pf;
    end
  end

endmodule // bpw_gen

// [verification/bpw_bridge_model.sv]
// bpw_bridge_model.sv: two half-bridge legs as a passive gate-driver load
// assumes: armed only in modes where a/e and b/f share a leg
`timescale 1ns/1ns
module bpw_bridge_model (
  input  wire       ref_clk,
  input  wire       armed,
  input  wire [1:0] hi_gate,
  input  wire [1:0] lo_gate,
  output reg  [7:0] shoot_cnt
);
  initial shoot_cnt = 8'h00;
  // both switches of one leg on would short the rail
  always @(posedge ref_clk)
    if (armed && (hi_gate & lo_gate) != 2'h0)
      shoot_cnt <= shoot_cnt + 8'h01;
endmodule // bpw_bridge_model

// [verification/bpw_checker.sv]
// bpw_checker.sv: port assertions for bpw_gen
// assumes: mode changes only while disabled, bar direction swaps
`timescale 1ns/1ns
`include "bpw_defs.vh"
module bpw_checker (
  input wire                   ref_clk,
  input wire                   srst,
  input wire                   enable,
  input wire [`BPW_MODE_W-1:0] mode,
  input wire                   db_rise_en,
  input wire                   db_fall_en,
  input wire [`BPW_DB_W-1:0]   db_rise_time,
  input wire [`BPW_DB_W-1:0]   db_fall_time,
  input wire                   out_a,
  input wire                   out_b,
  input wire                   out_c,
  input wire                   out_d,
  input wire                   out_e,
  input wire                   out_f
);
  wire       prim = out_a | out_b;
  wire       comp = out_e & out_f;
  wire       ppc  = enable && mode == `BPW_MODE_PPC;
  reg  [8:0] gap_q;
  reg        prim_q;
  reg        comp_q;
  reg        pf_q;
  // gap_q: cycles since prim or comp last moved, saturating
  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      prim_q <= 1'b0;
      comp_q <= 1'b0;
      pf_q   <= 1'b0;
      gap_q  <= 9'h001;
    end
    else
    begin
      prim_q <= prim;
      comp_q <= comp;
      pf_q   <= (prim_q && !prim) | (pf_q && comp == comp_q);
      if (prim != prim_q || comp != comp_q)
        gap_q <= 9'h001;
      else if (gap_q != 9'h1FF)
        gap_q <= gap_q + 9'h001;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  AST_LEGS: assert property (ppc |-> !(out_a && out_e) && !(out_b && out_f))
    else $error("leg overlap");
  AST_RISE_GAP: assert property (ppc && db_rise_en && $rose(prim) |-> gap_q == {1'b0, db_rise_time})
    else $error("rising dead band length");
  AST_FALL_GAP: assert property (ppc && db_fall_en && pf_q && $rose(comp) |-> gap_q == {1'b0, db_fall_time})
    else $error("falling dead band length");
  AST_NO_DB_SWAP: assert property (enable && mode == `BPW_MODE_PPFBC && !db_rise_en && $rose(out_a) |-> $fell(out_e))
    else $error("swap not in one cycle");
  AST_FB_PAIRS: assert property (enable && (mode == `BPW_MODE_PPFB || mode == `BPW_MODE_PPFBC) |-> out_a == out_c && out_b == out_d)
    else $error("bridge pair differs");
  AST_FWD_STATIC: assert property (enable && mode == `BPW_MODE_FBFWD && out_a |-> out_d && !out_b && !out_c)
    else $error("forward static outputs");
  AST_REV_STATIC: assert property (enable && mode == `BPW_MODE_FBREV && out_b |-> out_c && !out_a && !out_d)
    else $error("reverse static outputs");
  AST_PSK_ONLY_A: assert property (enable && mode == `BPW_MODE_PSK |-> !(out_b | out_c | out_d | out_e | out_f))
    else $error("pulse skip drives extra output");
  cover property (ppc && $rose(out_b));
  cover property (enable && mode == `BPW_MODE_PSK && $rose(out_a));
  cover property (enable && mode == `BPW_MODE_FBREV && $rose(out_b));
endmodule // bpw_checker

bind bpw_gen bpw_checker bpw_checker_inst (.ref_clk(ref_clk), .srst(srst), .enable(enable), .mode(mode),
  .db_rise_en(db_rise_en), .db_fall_en(db_fall_en), .db_rise_time(db_rise_time), .db_fall_time(db_fall_time),
  .out_a(out_a), .out_b(out_b), .out_c(out_c), .out_d(out_d), .out_e(out_e), .out_f(out_f));

// [verification/bpw_gen_bench.sv]
// bpw_gen_bench.sv: self-checking bench for bpw_gen
// assumes: checker bound in; dead band 4 rising, 3 falling
`timescale 1ns/1ns
`include "bpw_defs.vh"
module bpw_gen_bench;
  reg                   ref_clk = 1'b0;
  reg                   srst = 1'b1;
  reg                   enable = 1'b0;
  reg [`BPW_MODE_W-1:0] mode = `BPW_MODE_PPC;
  reg                   db_en = 1'b1;
  reg                   period_evt = 1'b0;
  reg                   rise_evt = 1'b0;
  reg                   fall_evt = 1'b0;
  reg [`BPW_RISE_W-1:0] async_rise_in = 4'h0;
  reg [`BPW_RISE_W-1:0] rise_en = 4'h1;
  wire                  out_a, out_b, out_c, out_d, out_e, out_f;
  wire [7:0]            shoot_cnt;
  wire [5:0]            outs = {out_a, out_b, out_c, out_d, out_e, out_f};
  integer               n_errors = 0;
  integer               check_count = 0;
  integer               n;
  always #25 ref_clk = ~ref_clk;
  bpw_gen bpw_gen_inst (.ref_clk(ref_clk), .srst(srst), .enable(enable), .mode(mode), .db_rise_en(db_en),
    .db_fall_en(db_en), .db_rise_time(8'h04), .db_fall_time(8'h03), .period_evt(period_evt),
    .rise_evt(rise_evt), .fall_evt(fall_evt), .async_rise_in(async_rise_in), .async_rise_en(rise_en),
    .out_a(out_a), .out_b(out_b), .out_c(out_c), .out_d(out_d), .out_e(out_e), .out_f(out_f));
  bpw_bridge_model bpw_bridge_model_inst (.ref_clk(ref_clk), .armed(enable && mode == `BPW_MODE_PPC),
    .hi_gate({out_a, out_b}), .lo_gate({out_e, out_f}), .shoot_cnt(shoot_cnt));
  task check(input [7:0] seen, input [7:0] exp);
  begin
    check_count = check_count + 1;
    if (seen !== exp)
    begin
      n_errors = n_errors + 1;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  end
  endtask
  // k: 0 period, 1 rise, 2 fall; long settle covers dead band plus pipeline
  task ev(input [1:0] k);
  begin
    @(posedge ref_clk);
    period_evt <= k == 2'h0;
    rise_evt   <= k == 2'h1;
    fall_evt   <= k == 2'h2;
    @(posedge ref_clk);
    {period_evt, rise_evt, fall_evt} <= 3'h0;
    repeat (10) @(posedge ref_clk);
    #1;
  end
  endtask
  task start(input [2:0] m, input d);
  begin
    @(posedge ref_clk);
    enable <= 1'b0;
    mode   <= m;
    db_en  <= d;
    repeat (4) @(posedge ref_clk);
    enable <= 1'b1;
    repeat (4) @(posedge ref_clk);
  end
  endtask
  // run one period, check after rise and after fall
  task cycle(input [5:0] hi, input [5:0] lo);
  begin
    ev(2'h0);
    ev(2'h1);
    check({2'h0, outs}, {2'h0, hi});
    ev(2'h2);
    check({2'h0, outs}, {2'h0, lo});
  end
  endtask
  task swap(input [2:0] m, input [7:0] exp);
  begin
    @(posedge ref_clk);
    mode <= m;
    n = 0;
    repeat (20)
    begin
      @(posedge ref_clk);
      #1;
      if (outs === 6'h00)
        n = n + 1;
    end
    check(n[7:0], exp);
  end
  endtask
  task end_of_test;
  begin
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  end
  endtask
  task test_pp_comp;
  begin
    start(`BPW_MODE_PPC, 1'b1);
    cycle(6'h21, 6'h03);
    cycle(6'h12, 6'h03);
    cycle(6'h21, 6'h03);
    $display("push-pull complementary done");
  end
  endtask
  task test_pp_bridge;
  begin
    start(`BPW_MODE_PPFB, 1'b0);
    cycle(6'h28, 6'h00);
    cycle(6'h14, 6'h00);
    start(`BPW_MODE_PPFBC, 1'b0);
    cycle(6'h29, 6'h03);
    cycle(6'h16, 6'h03);
    $display("push-pull bridge done");
  end
  endtask
  // disabled qualifier input must not fire a pulse, enabled one must
  task test_pulse_skip;
  begin
    start(`BPW_MODE_PSK, 1'b0);
    cycle(6'h00, 6'h00);
    @(posedge ref_clk);
    async_rise_in <= 4'h2;
    repeat (4) @(posedge ref_clk);
    cycle(6'h00, 6'h00);
    @(posedge ref_clk);
    rise_en <= 4'h3;
    repeat (4) @(posedge ref_clk);
    cycle(6'h20, 6'h00);
    start(`BPW_MODE_PSKC, 1'b1);
    cycle(6'h20, 6'h10);
    $display("pulse skip done");
  end
  endtask
  task test_full_bridge;
  begin
    start(`BPW_MODE_FBFWD, 1'b0);
    cycle(6'h24, 6'h04);
    swap(`BPW_MODE_FBREV, 8'h04);
    cycle(6'h18, 6'h08);
    swap(`BPW_MODE_FBFWD, 8'h05);
    start(3'h7, 1'b0);
    cycle(6'h00, 6'h00);
    $display("full bridge done");
  end
  endtask
  initial
  begin
    repeat (8) @(posedge ref_clk);
    srst <= 1'b0;
    test_pp_comp;
    test_pp_bridge;
    test_pulse_skip;
    test_full_bridge;
    check(shoot_cnt, 8'h00);
    end_of_test;
  end
endmodule // bpw_gen_bench
